// file: logic/ebi_pkg.sv
package ebi_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam logic [2:0] WBUF_FULL = 3'h4;
  localparam logic [3:0] RF_FULL = 4'h8;
  localparam logic [1:0] XB_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_MAP = 8'h08;
  localparam logic [7:0] OFS_GPCFG = 8'h0c;
  localparam logic [7:0] OFS_RD_ADDR = 8'h10;
  localparam logic [7:0] OFS_RD_SIZE = 8'h14;
  localparam logic [7:0] OFS_RD_CTRL = 8'h18;
  localparam logic [7:0] OFS_RD_COUNT = 8'h1c;
  localparam logic [7:0] OFS_RD_AVAIL = 8'h20;
  localparam logic [7:0] OFS_RD_DATA = 8'h24;
  localparam logic [7:0] OFS_WR_FREE = 8'h28;
  localparam logic [7:0] OFS_FIFO_CFG = 8'h2c;
  localparam logic [7:0] OFS_INT_EN = 8'h30;
  localparam logic [7:0] OFS_INT_RAW = 8'h34;
  localparam logic [7:0] OFS_INT_MASKED = 8'h38;
  localparam logic [7:0] OFS_ERR = 8'h3c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_FRAME_EN_BIT = 4;
  localparam int GP_HOLD_LSB = 8;
  localparam int GP_CLKEN_BIT = 16;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CFG_WR_TRIG_LSB = 4;
  localparam int CFG_RD_ERR_EN_BIT = 8;
  localparam int CFG_WR_ERR_EN_BIT = 9;
  localparam int CFG_DMA_EN_BIT = 10;
  localparam int ERR_TIMEOUT = 0;
  localparam int ERR_RD_STALL = 1;
  localparam int ERR_WR_STALL = 2;
  localparam int INT_RD = 0;
  localparam int INT_WR = 1;
  localparam int INT_ERR = 2;

  // ----------------------------------------------------------------
  // windows, lanes, types
  // ----------------------------------------------------------------
  localparam logic [3:0][31:0] WIN_MASK = {32'h1fff_ffff, 32'h00ff_ffff, 32'h0000_ffff, 32'h0000_00ff};
  localparam logic [31:0] PER_BASE_A = 32'ha000_0000;
  localparam logic [31:0] PER_BASE_C = 32'hc000_0000;
  localparam logic [31:0] MEM_BASE_6 = 32'h6000_0000;
  localparam logic [31:0] MEM_BASE_8 = 32'h8000_0000;
  localparam logic [1:0] BASE_SEL_NONE = 2'h0;
  localparam logic [1:0] BASE_SEL_LOW = 2'h1;
  localparam logic [1:0] BASE_SEL_HIGH = 2'h2;
  localparam logic [31:0] LANE_MASK_8 = 32'h0000_00ff;
  localparam logic [31:0] LANE_MASK_16 = 32'h0000_ffff;
  localparam logic [31:0] LANE_MASK_32 = 32'hffff_ffff;
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;

  typedef enum logic [1:0] {MODE_SDRAM = 2'h0, MODE_HB8 = 2'h1, MODE_HOST_BUS_16BIT_MODE = 2'h2, MODE_GP = 2'h3} ebi_mode_type;
  typedef enum logic [1:0] {XS_IDLE = 2'b00, XS_WAIT = 2'b01, XS_END = 2'b11} ebi_xstate_type;
  typedef enum logic [1:0] {SRC_WR = 2'h0, SRC_CPU = 2'h1, SRC_SEQ = 2'h2} ebi_src_type;

endpackage

// file: logic/ebi_front_end.sv
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/10ps
// Contract
// - buffer up to four pending processor writes
// - full buffer holds processor write off
// - readable count of free write slots
// - sequential reads ascend into read fifo
// - read fifo drained by polling, interrupt, dma
// - explicit start; stop halts further reads
// - report remaining reads and fifo fill
// - fifo items sized 32, 16 or 8 bits
// - programmable triggers; stall error interrupts
// - per-source enables; raw or masked status
// - report error cause, clear on command
// - peripheral window size 256B to 512MB
// - peripheral base none, 0xA..., 0xC...
// - memory window size chosen independently
// - memory base none, 0x6..., 0x8...
// - exactly one of four interface modes
// - divider sets external bus clock
// - window loads/stores become external transactions
// - framing length 0 to 15 clocks
// - hold-off limit 0 to 255 clocks
// - zero waits forever; overrun aborts, flags
module ebi_front_end (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pa_cyc_i,
  input wire logic pa_stb_i,
  input wire logic pa_we_i,
  input wire logic [31:0] pa_adr_i,
  input wire logic [31:0] pa_dat_i,
  output logic [31:0] pa_dat_o,
  output logic pa_ack_o,
  output logic xb_clk_o,
  output logic [28:0] xb_addr_o,
  output logic [31:0] xb_dat_o,
  output logic xb_dat_oe_o,
  input wire logic [31:0] xb_dat_i,
  output logic xb_rd_o,
  output logic xb_wr_o,
  output logic xb_frame_o,
  input wire logic xb_clken_i,
  output ebi_pkg::ebi_mode_type mode_o,
  output logic dma_req_o,
  output logic irq_o
);
  import ebi_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ebi_mode_type mode;
    logic frame_en;
    logic [15:0] div;
    logic [7:0] map;
    logic [3:0] frame_len;
    logic [7:0] holdoff_limit;
    logic clken_use;
    logic [31:0] rd_addr;
    logic [1:0] rd_size;
    logic [15:0] rd_count;
    logic rd_run;
    logic [10:0] fifo_cfg;
    logic [2:0] int_en;
    logic [2:0] err;
    logic [15:0] div_cnt;
    logic xb_clk;
    logic tick;
    logic [3:0][63:0] wbuf;
    logic [1:0] wb_rp;
    logic [1:0] wb_wp;
    logic [2:0] wb_cnt;
    logic [7:0][31:0] rf;
    logic [2:0] rf_rp;
    logic [2:0] rf_wp;
    logic [3:0] rf_cnt;
    ebi_xstate_type st;
    ebi_src_type src;
    logic [3:0] frame_cnt;
    logic [7:0] hold_cnt;
    logic [1:0] settle;
    logic [28:0] xb_addr;
    logic [31:0] xb_dout;
    logic xb_oe;
    logic xb_rd;
    logic xb_wr;
    logic xb_frame;
    logic clken_s1;
    logic clken_s2;
    logic [31:0] dat_s1;
    logic [31:0] dat_s2;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic pa_ack;
    logic [31:0] pa_dat;
  } ebi_state_type;

  ebi_state_type s_q;
  ebi_state_type s_d;

  logic reg_req;
  logic reg_fire;
  logic pa_req;
  logic [31:0] per_mask;
  logic [31:0] mem_mask;
  logic [31:0] per_base;
  logic [31:0] mem_base;
  logic per_hit;
  logic mem_hit;
  logic win_hit;
  logic [28:0] win_off;
  logic xb_ready;
  logic [31:0] lane_mask;
  logic [31:0] step;
  logic [2:0] wr_free;
  logic [2:0] int_raw;
  logic [31:0] byte_mask;
  logic [31:0] merged;
  logic [31:0] rdata;

  function automatic logic [31:0] size_data(input logic [31:0] d, input logic [1:0] sz);
    if (sz == SIZE_8) begin
      return d & LANE_MASK_8;
    end else if (sz == SIZE_16) begin
      return d & LANE_MASK_16;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign reg_req = wb_cyc_i & wb_stb_i & ~s_q.wb_ack;
  assign reg_fire = wb_cyc_i & wb_stb_i & s_q.wb_ack;
  assign pa_req = pa_cyc_i & pa_stb_i & ~s_q.pa_ack;
  assign per_mask = WIN_MASK[s_q.map[1:0]];
  assign mem_mask = WIN_MASK[s_q.map[5:4]];
  assign per_base = (s_q.map[3:2] == BASE_SEL_LOW) ? PER_BASE_A : PER_BASE_C;
  assign mem_base = (s_q.map[7:6] == BASE_SEL_LOW) ? MEM_BASE_6 : MEM_BASE_8;
  assign per_hit = (s_q.map[3:2] == BASE_SEL_LOW || s_q.map[3:2] == BASE_SEL_HIGH) &&
                   ((pa_adr_i & ~per_mask) == per_base);
  assign mem_hit = (s_q.map[7:6] == BASE_SEL_LOW || s_q.map[7:6] == BASE_SEL_HIGH) &&
                   ((pa_adr_i & ~mem_mask) == mem_base);
  assign win_hit = per_hit | mem_hit;
  assign win_off = per_hit ? pa_adr_i[28:0] & per_mask[28:0] : pa_adr_i[28:0] & mem_mask[28:0];
  assign xb_ready = (s_q.mode != MODE_GP) || !s_q.clken_use || s_q.clken_s2;
  assign lane_mask = (s_q.mode == MODE_HB8) ? LANE_MASK_8 :
                     (s_q.mode == MODE_HOST_BUS_16BIT_MODE) ? LANE_MASK_16 : LANE_MASK_32;
  assign step = (s_q.rd_size == SIZE_8) ? 32'h1 : (s_q.rd_size == SIZE_16) ? 32'h2 : 32'h4;
  assign wr_free = WBUF_FULL - s_q.wb_cnt;
  assign int_raw[INT_RD] = (s_q.fifo_cfg[3:0] != 4'h0) && (s_q.rf_cnt >= s_q.fifo_cfg[3:0]);
  assign int_raw[INT_WR] = (s_q.fifo_cfg[6:4] != 3'h0) && (wr_free >= s_q.fifo_cfg[6:4]);
  assign int_raw[INT_ERR] = |s_q.err;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign byte_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    merged = 32'h0;
    rdata = 32'h0;
    case (wb_adr_i)
      OFS_MODE: begin
        merged[1:0] = s_q.mode;
        merged[MODE_FRAME_EN_BIT] = s_q.frame_en;
      end
      OFS_DIV: merged[15:0] = s_q.div;
      OFS_MAP: merged[7:0] = s_q.map;
      OFS_GPCFG: begin
        merged[3:0] = s_q.frame_len;
        merged[GP_HOLD_LSB +: 8] = s_q.holdoff_limit;
        merged[GP_CLKEN_BIT] = s_q.clken_use;
      end
      OFS_RD_ADDR: merged = s_q.rd_addr;
      OFS_RD_SIZE: merged[1:0] = s_q.rd_size;
      OFS_RD_CTRL: merged[CTRL_START_BIT] = s_q.rd_run;
      OFS_RD_COUNT: merged[15:0] = s_q.rd_count;
      OFS_RD_AVAIL: merged[3:0] = s_q.rf_cnt;
      OFS_RD_DATA: merged = (s_q.rf_cnt != 4'h0) ? s_q.rf[s_q.rf_rp] : 32'h0;
      OFS_WR_FREE: merged[2:0] = wr_free;
      OFS_FIFO_CFG: merged[10:0] = s_q.fifo_cfg;
      OFS_INT_EN: merged[2:0] = s_q.int_en;
      OFS_INT_RAW: merged[2:0] = int_raw;
      OFS_INT_MASKED: merged[2:0] = int_raw & s_q.int_en;
      OFS_ERR: merged[2:0] = s_q.err;
      default: merged = 32'h0;
    endcase
    rdata = merged;
    merged = (merged & ~byte_mask) | (wb_dat_i & byte_mask);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic push_w;
    logic pop_w;
    logic push_r;
    logic pop_r;
    logic go;
    logic done;
    logic abort;
    push_w = 1'b0;
    pop_w = 1'b0;
    push_r = 1'b0;
    pop_r = 1'b0;
    go = 1'b0;
    done = 1'b0;
    abort = 1'b0;
    s_d = s_q;
    s_d.clken_s1 = xb_clken_i;
    s_d.clken_s2 = s_q.clken_s1;
    s_d.dat_s1 = xb_dat_i;
    s_d.dat_s2 = s_q.dat_s1;
    s_d.tick = 1'b0;
    s_d.wb_ack = 1'b0;
    s_d.pa_ack = 1'b0;
    if (s_q.div_cnt >= s_q.div) begin
      s_d.div_cnt = 16'h0;
      s_d.tick = 1'b1;
      s_d.xb_clk = ~s_q.xb_clk;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 16'h1;
    end

    // register writes land on the edge that sees ack
    if (reg_fire && wb_we_i) begin
      case (wb_adr_i)
        OFS_MODE: begin
          s_d.mode = ebi_mode_type'(merged[1:0]);
          s_d.frame_en = merged[MODE_FRAME_EN_BIT];
        end
        OFS_DIV: s_d.div = merged[15:0];
        OFS_MAP: s_d.map = merged[7:0];
        OFS_GPCFG: begin
          s_d.frame_len = merged[3:0];
          s_d.holdoff_limit = merged[GP_HOLD_LSB +: 8];
          s_d.clken_use = merged[GP_CLKEN_BIT];
        end
        OFS_RD_ADDR: s_d.rd_addr = merged;
        OFS_RD_SIZE: s_d.rd_size = merged[1:0];
        OFS_RD_CTRL: begin
          if (wb_dat_i[CTRL_START_BIT] && s_q.rd_count != 16'h0) begin
            s_d.rd_run = 1'b1;
          end
          if (wb_dat_i[CTRL_STOP_BIT]) begin
            s_d.rd_run = 1'b0;
          end
        end
        OFS_RD_COUNT: begin
          if (!s_q.rd_run) begin
            s_d.rd_count = merged[15:0];
          end
        end
        OFS_FIFO_CFG: s_d.fifo_cfg = merged[10:0];
        OFS_INT_EN: s_d.int_en = merged[2:0];
        OFS_ERR: s_d.err = s_q.err & ~wb_dat_i[2:0];
        default: s_d.err = s_d.err;
      endcase
    end
    if (reg_fire && !wb_we_i && wb_adr_i == OFS_RD_DATA && s_q.rf_cnt != 4'h0) begin
      pop_r = 1'b1;
    end

    // register answer; an empty fifo with reads pending stalls the poll
    if (reg_req) begin
      if (!wb_we_i && wb_adr_i == OFS_RD_DATA && s_q.rf_cnt == 4'h0 && s_q.rd_run) begin
        if (s_q.fifo_cfg[CFG_RD_ERR_EN_BIT]) begin
          s_d.err[ERR_RD_STALL] = 1'b1;
        end
      end else begin
        s_d.wb_ack = 1'b1;
        s_d.wb_dat = rdata;
      end
    end

    // processor side
    if (pa_req && !win_hit) begin
      s_d.pa_ack = 1'b1;
      s_d.pa_dat = 32'h0;
    end else if (pa_req && pa_we_i) begin
      if (s_q.wb_cnt < WBUF_FULL) begin
        push_w = 1'b1;
        s_d.pa_ack = 1'b1;
      end else if (s_q.fifo_cfg[CFG_WR_ERR_EN_BIT]) begin
        s_d.err[ERR_WR_STALL] = 1'b1;
      end
    end

    // external transaction engine
    case (s_q.st)
      XS_IDLE: begin
        s_d.hold_cnt = 8'h0;
        if (s_q.wb_cnt != 3'h0) begin
          go = 1'b1;
          s_d.src = SRC_WR;
          s_d.xb_addr = s_q.wbuf[s_q.wb_rp][60:32];
          s_d.xb_dout = s_q.wbuf[s_q.wb_rp][31:0] & lane_mask;
          s_d.xb_oe = 1'b1;
          s_d.xb_wr = 1'b1;
        end else if (pa_req && win_hit && !pa_we_i) begin
          go = 1'b1;
          s_d.src = SRC_CPU;
          s_d.xb_addr = win_off;
          s_d.xb_rd = 1'b1;
        end else if (s_q.rd_run && s_q.rd_count != 16'h0 && s_q.rf_cnt < RF_FULL) begin
          go = 1'b1;
          s_d.src = SRC_SEQ;
          s_d.xb_addr = s_q.rd_addr[28:0];
          s_d.xb_rd = 1'b1;
        end
        if (go) begin
          s_d.st = XS_WAIT;
          s_d.settle = XB_SETTLE;
          s_d.frame_cnt = (s_q.mode == MODE_GP && s_q.frame_en) ? s_q.frame_len : 4'h0;
          s_d.xb_frame = (s_q.mode == MODE_GP && s_q.frame_en && s_q.frame_len != 4'h0);
        end
      end
      XS_WAIT: begin
        if (s_q.settle != 2'h0) begin
          s_d.settle = s_q.settle - 2'h1;
        end
        if (s_q.tick) begin
          if (s_q.frame_cnt != 4'h0) begin
            s_d.frame_cnt = s_q.frame_cnt - 4'h1;
            s_d.xb_frame = (s_q.frame_cnt != 4'h1);
          end else if (s_q.settle != 2'h0) begin
            // read data still crossing the synchroniser
            s_d.hold_cnt = s_q.hold_cnt;
          end else if (xb_ready) begin
            done = 1'b1;
          end else if (s_q.holdoff_limit != 8'h0 && s_q.hold_cnt == s_q.holdoff_limit) begin
            abort = 1'b1;
            s_d.err[ERR_TIMEOUT] = 1'b1;
          end else begin
            s_d.hold_cnt = s_q.hold_cnt + 8'h1;
          end
        end
        if (done || abort) begin
          s_d.st = XS_END;
          s_d.xb_rd = 1'b0;
          s_d.xb_wr = 1'b0;
          s_d.xb_oe = 1'b0;
          s_d.xb_frame = 1'b0;
          case (s_q.src)
            SRC_WR: pop_w = 1'b1;
            SRC_CPU: begin
              s_d.pa_ack = 1'b1;
              s_d.pa_dat = done ? s_q.dat_s2 & lane_mask : 32'h0;
            end
            default: begin
              if (done) begin
                push_r = 1'b1;
                s_d.rf[s_q.rf_wp] = size_data(s_q.dat_s2 & lane_mask, s_q.rd_size);
                s_d.rd_addr = s_q.rd_addr + step;
                s_d.rd_count = s_q.rd_count - 16'h1;
                if (s_q.rd_count == 16'h1) begin
                  s_d.rd_run = 1'b0;
                end
              end else begin
                s_d.rd_run = 1'b0;
              end
            end
          endcase
        end
      end
      XS_END: s_d.st = XS_IDLE;
      default: s_d.st = XS_IDLE;
    endcase

    // fifo bookkeeping
    if (push_w) begin
      s_d.wbuf[s_q.wb_wp] = {3'h0, win_off, pa_dat_i};
      s_d.wb_wp = s_q.wb_wp + 2'h1;
    end
    if (pop_w) begin
      s_d.wb_rp = s_q.wb_rp + 2'h1;
    end
    s_d.wb_cnt = s_q.wb_cnt + {2'h0, push_w} - {2'h0, pop_w};
    if (push_r) begin
      s_d.rf_wp = s_q.rf_wp + 3'h1;
    end
    if (pop_r) begin
      s_d.rf_rp = s_q.rf_rp + 3'h1;
    end
    s_d.rf_cnt = s_q.rf_cnt + {3'h0, push_r} - {3'h0, pop_r};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = s_q.wb_dat;
  assign wb_ack_o = s_q.wb_ack;
  assign pa_dat_o = s_q.pa_dat;
  assign pa_ack_o = s_q.pa_ack;
  assign xb_clk_o = s_q.xb_clk;
  assign xb_addr_o = s_q.xb_addr;
  assign xb_dat_o = s_q.xb_dout;
  assign xb_dat_oe_o = s_q.xb_oe;
  assign xb_rd_o = s_q.xb_rd;
  assign xb_wr_o = s_q.xb_wr;
  assign xb_frame_o = s_q.xb_frame;
  assign mode_o = s_q.mode;
  assign dma_req_o = s_q.fifo_cfg[CFG_DMA_EN_BIT] & int_raw[INT_RD];
  assign irq_o = |(int_raw & s_q.int_en);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_seq_done;
    s_q.st == XS_WAIT && s_q.src == SRC_SEQ && s_q.tick && s_q.frame_cnt == 4'h0 && xb_ready &&
    s_q.settle == 2'h0;
  endsequence
  sequence s_stop_cmd;
    reg_fire && wb_we_i && wb_adr_i == OFS_RD_CTRL && wb_dat_i[CTRL_STOP_BIT];
  endsequence

  a_wbuf_bound: assert property (s_q.wb_cnt <= WBUF_FULL)
    else $error("write buffer over four");
  a_wr_held_off: assert property (pa_req && win_hit && pa_we_i && s_q.wb_cnt == WBUF_FULL |=> !s_q.pa_ack)
    else $error("write acked while buffer full");
  a_free_count: assert property (reg_req && !wb_we_i && wb_adr_i == OFS_WR_FREE |=>
    wb_ack_o && wb_dat_o == {29'h0, $past(wr_free)})
    else $error("free slot count wrong");
  a_seq_addr_step: assert property (s_seq_done |=> s_q.rd_addr == $past(s_q.rd_addr) + $past(step))
    else $error("sequential address did not step");
  a_stop_halts: assert property (s_stop_cmd |=> !s_q.rd_run [*2])
    else $error("read engine still running after stop");
  a_miss_no_xfer: assert property (pa_req && !win_hit && s_q.st == XS_IDLE && s_q.wb_cnt == 3'h0 &&
    !s_q.rd_run |=> s_q.pa_ack && s_q.st == XS_IDLE)
    else $error("window miss started a transaction");
  a_read_after_wr: assert property (s_q.st == XS_IDLE && s_q.wb_cnt != 3'h0 |=> s_q.src != SRC_CPU ||
    s_q.st != XS_WAIT)
    else $error("read overtook buffered write");
  a_holdoff_abort: assert property ($rose(s_q.err[ERR_TIMEOUT]) |-> $past(s_q.holdoff_limit) != 8'h0 &&
    $past(s_q.hold_cnt) == $past(s_q.holdoff_limit))
    else $error("timeout without reaching limit");

endmodule

// file: verification/ebi_xmem.sv
`timescale 1ns/10ps
module ebi_xmem (
  input wire logic clk_i,
  input wire logic [28:0] addr_i,
  input wire logic [31:0] wdat_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic rdy_i,
  output logic [31:0] rdat_o,
  output logic ready_o,
  output int xacts_o
);
  logic [31:0] mem [256];
  logic [31:0] last_q;
  logic act_q;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {8'h3c, 8'(i) ^ 8'hc3, 8'h5a, 8'(i)};
    end
    last_q = 32'h0;
    act_q = 1'b0;
    xacts_o = 0;
  end
  // idle data line toggles so a stale value matches only every other cycle
  assign rdat_o = rd_i ? mem[addr_i[7:0]] : last_q;
  assign ready_o = rdy_i;
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[addr_i[7:0]] <= wdat_i;
    end
    last_q <= rd_i ? ~mem[addr_i[7:0]] : ~last_q;
    act_q <= rd_i | wr_i;
    if ((rd_i | wr_i) && !act_q) begin
      xacts_o <= xacts_o + 1;
    end
  end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import ebi_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, rdy = 1'b1;
  logic wb_cyc = 0, wb_stb = 0, wb_we = 0, pa_cyc = 0, pa_stb = 0, pa_we = 0;
  logic [7:0] wb_adr = 8'h0;
  logic [31:0] wb_dat = 0, pa_adr = 0, pa_dat = 0, rv, d;
  logic [31:0] wb_dat_o, pa_dat_o, xb_dat_o, xb_dat_i;
  logic [28:0] xb_addr_o;
  logic wb_ack_o, pa_ack_o, xb_rd_o, xb_wr_o, clken, dma_req_o, irq_o;
  ebi_mode_type mode_o;
  logic [63:0] q_w[$], q_p[$], n, w;
  logic xclk, xframe;
  int failures = 0, cmp_count = 0, cyc_n = 0, x0, xt = 0, fc = 0;
  time t0;
  always #20 clk_i = ~clk_i;
  ebi_front_end dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pa_cyc_i(pa_cyc), .pa_stb_i(pa_stb), .pa_we_i(pa_we), .pa_adr_i(pa_adr), .pa_dat_i(pa_dat),
    .pa_dat_o(pa_dat_o), .pa_ack_o(pa_ack_o), .xb_clk_o(xclk), .xb_addr_o(xb_addr_o), .xb_dat_o(xb_dat_o),
    .xb_dat_oe_o(), .xb_dat_i(xb_dat_i), .xb_rd_o(xb_rd_o), .xb_wr_o(xb_wr_o), .xb_frame_o(xframe),
    .xb_clken_i(clken), .mode_o(mode_o), .dma_req_o(dma_req_o), .irq_o(irq_o));
  ebi_xmem far (.clk_i(clk_i), .addr_i(xb_addr_o), .wdat_i(xb_dat_o), .rd_i(xb_rd_o), .wr_i(xb_wr_o),
    .rdy_i(rdy), .rdat_o(xb_dat_i), .ready_o(clken), .xacts_o(x0));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    cmp_count++;
    if ((g & m) !== (e & m)) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic x(input logic p, input logic we, input logic [31:0] a, input logic [31:0] dv,
      input logic [31:0] e, input logic [31:0] m);
    if (!we && p) q_p.push_back({m, e});
    if (!we && !p) q_w.push_back({m, e});
    @(posedge clk_i);
    if (p) begin
      pa_cyc <= 1'b1;
      pa_stb <= 1'b1;
      pa_we <= we;
      pa_adr <= a;
      pa_dat <= dv;
    end else begin
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a[7:0];
      wb_dat <= dv;
    end
    do @(posedge clk_i); while ((p ? pa_ack_o : wb_ack_o) !== 1'b1);
    rv = p ? pa_dat_o : wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    pa_cyc <= 1'b0;
    pa_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    x(1'b0, 1'b1, {24'h0, a}, dv, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    x(1'b0, 1'b0, {24'h0, a}, 32'h0, e, m);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    do rd(a, 32'h0, 32'h0); while ((rv & m) !== e);
  endtask
  // pop the oldest note on every read answer
  always @(xclk) xt++;
  always @(posedge clk_i) begin
    cyc_n++;
    if (xframe === 1'b1) fc++;
    if (cyc_n == 20000) begin
      failures++;
      finish_test();
    end
    if (wb_ack_o === 1'b1 && wb_cyc && !wb_we) begin
      w = q_w.pop_front();
      chk(wb_dat_o, w[31:0], w[63:32]);
    end
    if (pa_ack_o === 1'b1 && pa_cyc && !pa_we) begin
      w = q_p.pop_front();
      chk(pa_dat_o, w[31:0], w[63:32]);
    end
  end
  logic [31:0] hit[3] = '{32'ha000_00fc, 32'h6000_fffc, 32'ha000_0000};
  logic [31:0] miss[4] = '{32'ha000_0100, 32'h6001_0000, 32'hc000_0000, 32'h8000_0000};
  initial begin
    void'($urandom(32'h45a2));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_MODE, 32'h0, 32'hffff_ffff);
    rd(OFS_WR_FREE, 32'h4, 32'hffff_ffff);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    $display("test reset done");
    wr(OFS_MODE, {30'h0, MODE_GP});
    wr(OFS_MAP, 32'h54);
    chk({30'h0, mode_o}, {30'h0, MODE_GP}, 32'h3);
    foreach (hit[i]) begin
      d = $urandom;
      x(1'b1, 1'b1, hit[i], d, 32'h0, 32'h0);
      x(1'b1, 1'b0, hit[i], 32'h0, d, 32'hffff_ffff);
    end
    foreach (miss[i]) begin
      n[31:0] = x0;
      x(1'b1, 1'b1, miss[i], $urandom, 32'h0, 32'h0);
      x(1'b1, 1'b0, miss[i], 32'h0, 32'h0, 32'hffff_ffff);
      chk(x0, n[31:0], 32'hffff_ffff);
    end
    $display("test windows done");
    rdy <= 1'b0;
    wr(OFS_GPCFG, 32'h0001_0300);
    x(1'b1, 1'b1, 32'ha000_0004, 32'h1, 32'h0, 32'h0);
    poll(OFS_ERR, 32'h1, 32'h1);
    rd(OFS_INT_RAW, 32'h4, 32'h4);
    wr(OFS_ERR, 32'h1);
    rd(OFS_ERR, 32'h0, 32'h1);
    $display("test holdoff done");
    wr(OFS_GPCFG, 32'h0001_0000);
    wr(OFS_FIFO_CFG, 32'h200);
    t0 = $time;
    for (int i = 0; i < 4; i++) x(1'b1, 1'b1, 32'ha000_0080, i, 32'h0, 32'h0);
    chk(32'(($time - t0) < 1200), 32'h1, 32'h1);
    fork
      begin
        repeat (60) @(posedge clk_i);
        rdy <= 1'b1;
      end
    join_none
    t0 = $time;
    for (int i = 4; i < 6; i++) x(1'b1, 1'b1, 32'ha000_0080, i, 32'h0, 32'h0);
    chk(32'(($time - t0) > 2400), 32'h1, 32'h1);
    poll(OFS_WR_FREE, 32'h4, 32'hf);
    rd(OFS_ERR, 32'h4, 32'h5);
    wr(OFS_ERR, 32'h4);
    x(1'b1, 1'b0, 32'ha000_0080, 32'h0, 32'h5, 32'hffff_ffff);
    wr(OFS_GPCFG, 32'h0);
    $display("test write buffer done");
    wr(OFS_FIFO_CFG, 32'h402);
    wr(OFS_INT_EN, 32'h1);
    wr(OFS_RD_ADDR, 32'ha000_0040);
    wr(OFS_RD_SIZE, 32'h2);
    wr(OFS_RD_COUNT, 32'h3);
    wr(OFS_RD_CTRL, 32'h1);
    poll(OFS_RD_AVAIL, 32'h3, 32'hf);
    rd(OFS_RD_COUNT, 32'h0, 32'hffff_ffff);
    chk({30'h0, dma_req_o, irq_o}, 32'h3, 32'h3);
    rd(OFS_INT_MASKED, 32'h1, 32'h1);
    wr(OFS_INT_EN, 32'h0);
    rd(OFS_INT_RAW, 32'h1, 32'h1);
    rd(OFS_INT_MASKED, 32'h0, 32'h1);
    for (int i = 0; i < 3; i++) rd(OFS_RD_DATA, {8'h3c, 8'(64 + 4 * i) ^ 8'hc3, 8'h5a, 8'(64 + 4 * i)}, '1);
    chk({31'h0, dma_req_o}, 32'h0, 32'h1);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_RD_SIZE, s);
      wr(OFS_RD_ADDR, 32'ha000_0050);
      wr(OFS_RD_COUNT, 32'h2);
      wr(OFS_RD_CTRL, 32'h1);
      for (int i = 0; i < 2; i++) rd(OFS_RD_DATA, {16'h5a, 8'(80 + i * (s + 1))}, s ? 32'hffff : 32'hff);
    end
    $display("test read fifo done");
    wr(OFS_RD_COUNT, 32'h8);
    wr(OFS_RD_CTRL, 32'h3);
    rd(OFS_RD_CTRL, 32'h0, 32'h1);
    rd(OFS_RD_COUNT, 32'h8, 32'hffff_ffff);
    wr(OFS_RD_CTRL, 32'h1);
    wr(OFS_RD_CTRL, 32'h2);
    rd(OFS_RD_CTRL, 32'h0, 32'h1);
    n[31:0] = x0;
    repeat (30) @(posedge clk_i);
    chk(x0, n[31:0], 32'hffff_ffff);
    $display("test stop done");
    wr(OFS_MODE, 32'h13);
    wr(OFS_GPCFG, 32'h3);
    n[31:0] = fc;
    x(1'b1, 1'b1, 32'ha000_0020, 32'h0, 32'h0, 32'h0);
    poll(OFS_WR_FREE, 32'h4, 32'hf);
    chk(fc, n[31:0] + 32'h3, 32'hffff_ffff);
    wr(OFS_DIV, 32'h3);
    n[31:0] = xt;
    repeat (40) @(posedge clk_i);
    chk(xt, n[31:0] + 32'ha, 32'hffff_ffff);
    wr(OFS_MAP, 32'hb6);
    for (int k = 1; k < 3; k++) begin
      wr(OFS_MODE, k);
      n = {$urandom, k == 1 ? 32'ha0ff_fff0 : 32'h9fff_fff0};
      x(1'b1, 1'b1, n[31:0], n[63:32], 32'h0, 32'h0);
      d = n[63:32] & (k == 1 ? LANE_MASK_8 : LANE_MASK_16);
      x(1'b1, 1'b0, n[31:0], 32'h0, d, 32'hffff_ffff);
    end
    $display("test modes done");
    finish_test();
  end
endmodule
